// ==== hdl/icp_slave.sv ====
// two-wire slave port with seven configuration registers
`timescale 1ns/1ps
module icp_slave (
	input wire logic i_core_clk, // core clock, 125 MHz
	input wire logic i_rst_n, // power-on reset, active low
	input wire logic i_link_clk, // link sampling clock
	input wire logic i_scl, // serial clock pin level
	output logic o_scl_out, // serial clock drive value
	output logic o_scl_oe, // serial clock drive enable
	input wire logic i_sda, // serial data pin level
	output logic o_sda_out, // serial data drive value
	output logic o_sda_oe, // serial data pull-low enable
	input wire logic i_power_ok_in, // power-ok pin
	input wire logic [2:0] i_addr_sel, // address strap select
	output logic [7:0] o_northbridge_offset_ctrl, // register 0
	output logic [7:0] o_core_offset_ctrl, // register 1
	output logic [7:0] o_power_save_cfg, // register 2
	output logic [7:0] o_phase_gate_level_ctrl, // register 4
	output logic [7:0] o_min_phase_droop_cfg, // register 5
	output logic [7:0] o_slew_alignment_cfg // register 6
);
	import icp_pkg::*;

	// ==========================================================
	// link reset and input synchronisers
	logic [1:0] lrst_q;
	logic link_rst_n;
	logic [2:0] scl_q;
	logic [2:0] sda_q;
	logic [1:0] pok_q;
	logic [2:0] sel_q0;
	logic [2:0] sel_q1;
	logic scl_s;
	logic scl_p;
	logic sda_s;
	logic sda_p;
	logic pok_s;

	always_ff @(posedge i_link_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lrst_q <= 2'h0; // RQ14
		end else begin
			lrst_q <= {lrst_q[0], 1'b1};
		end
	end
	assign link_rst_n = lrst_q[1];

	// sampled far above 400 kbit/s bit time
	always_ff @(posedge i_link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			scl_q <= 3'h7;
			sda_q <= 3'h7;
			pok_q <= 2'h3;
			sel_q0 <= 3'h0;
			sel_q1 <= 3'h0;
		end else begin
			scl_q <= {scl_q[1:0], i_scl}; // RQ25 RQ13
			sda_q <= {sda_q[1:0], i_sda}; // RQ25
			pok_q <= {pok_q[0], i_power_ok_in};
			sel_q0 <= i_addr_sel;
			sel_q1 <= sel_q0;
		end
	end
	assign scl_s = scl_q[1];
	assign scl_p = scl_q[2];
	assign sda_s = sda_q[1];
	assign sda_p = sda_q[2];
	assign pok_s = pok_q[1];

	// ==========================================================
	// strap capture after reset release
	logic [1:0] cap_cnt;
	logic [6:0] my_addr;
	logic cap_done;

	always_ff @(posedge i_link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			cap_cnt <= 2'h0;
			my_addr <= SLAVE_ADDR[0];
		end else begin
			if (cap_cnt != CAP_DONE) begin
				cap_cnt <= cap_cnt + 2'h1;
			end
			if (cap_cnt == CAP_LOAD) begin
				my_addr <= SLAVE_ADDR[sel_q1]; // RQ26 RQ16
			end
		end
	end
	assign cap_done = (cap_cnt == CAP_DONE);

	// ==========================================================
	// bus event detection
	logic start_det;
	logic stop_det;
	logic scl_rise;
	logic scl_fall;

	assign start_det = scl_s & scl_p & sda_p & ~sda_s; // RQ2 RQ1
	assign stop_det = scl_s & scl_p & ~sda_p & sda_s; // RQ3 RQ1
	assign scl_rise = scl_s & ~scl_p;
	assign scl_fall = ~scl_s & scl_p;

	// ==========================================================
	// protocol engine
	icp_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic [7:0] tx;
	logic [2:0] ptr;
	logic sda_oe;
	logic m_nack;
	logic dirty;
	logic commit_tgl;
	logic byte_end;
	logic ack_end;
	logic wr_ok;
	logic shadow_wr;
	logic [7:0] rd_byte;
	logic [7:0] shadow [0:6];

	assign byte_end = scl_fall && (bit_cnt == BIT_ACK);
	assign ack_end = scl_fall && (bit_cnt == BIT_END);
	assign wr_ok = ({5'h00, ptr} <= ADDR_LAST) &&
		!(({5'h00, ptr} >= ADDR_LOCK_LO) && pok_s); // RQ20 RQ19
	assign shadow_wr = byte_end && (state == ST_WR) && wr_ok &&
		({5'h00, ptr} != ADDR_RSVD); // RQ19
	assign rd_byte = ({5'h00, ptr} <= ADDR_LAST) ? shadow[ptr] : 8'h00;

	always_ff @(posedge i_link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			state <= ST_IDLE;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			tx <= 8'h00;
			ptr <= 3'h0;
			sda_oe <= 1'b0;
			m_nack <= 1'b0;
			dirty <= 1'b0;
			commit_tgl <= 1'b0;
		end else if (start_det && cap_done) begin
			state <= ST_DEV; // RQ2
			bit_cnt <= 4'h0;
			sda_oe <= 1'b0;
		end else if (stop_det) begin
			state <= ST_IDLE; // RQ3
			bit_cnt <= 4'h0;
			sda_oe <= 1'b0;
			if (dirty) begin
				commit_tgl <= ~commit_tgl; // RQ24
				dirty <= 1'b0;
			end
		end else if (state != ST_IDLE) begin
			if (scl_rise) begin
				if (bit_cnt < BIT_ACK) begin
					shift <= {shift[6:0], sda_s}; // RQ6 RQ5
				end else if (bit_cnt == BIT_ACK) begin
					m_nack <= sda_s; // RQ7
				end
				if (bit_cnt != BIT_END) begin
					bit_cnt <= bit_cnt + 4'h1;
				end
			end else if (byte_end) begin
				unique case (state)
					ST_DEV: begin
						if (shift[7:1] == my_addr) begin
							sda_oe <= 1'b1; // RQ8
							state <= shift[0] ? ST_RD : ST_REGA; // RQ9 RQ17
						end else begin
							state <= ST_SKIP; // RQ10
						end
					end
					ST_REGA: begin
						if (shift <= ADDR_LAST) begin
							sda_oe <= 1'b1; // RQ21 RQ18
							ptr <= shift[2:0];
							state <= ST_WR;
						end else begin
							state <= ST_SKIP; // RQ19
						end
					end
					ST_WR: begin
						if (wr_ok) begin
							sda_oe <= 1'b1; // RQ7
							dirty <= 1'b1;
							ptr <= ptr + 3'h1; // RQ22
						end else begin
							state <= ST_SKIP; // RQ20
						end
					end
					ST_RD: begin
						sda_oe <= 1'b0;
						if (ptr != PTR_END) begin
							ptr <= ptr + 3'h1; // RQ23
						end
					end
					ST_IDLE, ST_SKIP: begin
						sda_oe <= 1'b0;
					end
				endcase
			end else if (ack_end) begin
				bit_cnt <= 4'h0;
				if ((state == ST_RD) && !m_nack) begin
					tx <= rd_byte; // RQ23
					sda_oe <= ~rd_byte[7]; // RQ6 RQ12
				end else begin
					sda_oe <= 1'b0; // RQ7
					if (state == ST_RD) begin
						state <= ST_SKIP; // RQ23
					end
				end
			end else if (scl_fall && (state == ST_RD) &&
				(bit_cnt != 4'h0) && (bit_cnt < BIT_ACK)) begin
				tx <= {tx[6:0], 1'b0};
				sda_oe <= ~tx[6]; // RQ6 RQ1
			end
		end
	end

	// ==========================================================
	// link-side register copy, only writer is the engine
	always_ff @(posedge i_link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				shadow[i] <= RST_VAL[i]; // RQ15
			end
		end else if (shadow_wr) begin
			shadow[ptr] <= shift; // RQ22
		end
	end

	assign o_scl_out = 1'b0; // RQ11
	assign o_scl_oe = 1'b0; // RQ11
	assign o_sda_out = 1'b0; // RQ12
	assign o_sda_oe = sda_oe; // RQ12

	// ==========================================================
	// core side: commit crossing and live registers
	logic [2:0] cm_q;
	logic commit_evt;
	logic [7:0] cfg [0:6];

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cm_q <= 3'h0;
		end else begin
			cm_q <= {cm_q[1:0], commit_tgl};
		end
	end
	assign commit_evt = cm_q[2] ^ cm_q[1];

	// shadow is quiet for microseconds after a stop
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				cfg[i] <= RST_VAL[i]; // RQ15
			end
		end else if (commit_evt) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				cfg[i] <= shadow[i]; // RQ24
			end
		end
	end

	assign o_northbridge_offset_ctrl = cfg[0];
	assign o_core_offset_ctrl = cfg[1];
	assign o_power_save_cfg = cfg[2];
	assign o_phase_gate_level_ctrl = cfg[4];
	assign o_min_phase_droop_cfg = cfg[5];
	assign o_slew_alignment_cfg = cfg[6];

	// ==========================================================
	// checks
	a_start_begins: assert property ( // RQ2
		@(posedge i_link_clk) disable iff (!link_rst_n)
		(start_det && cap_done) |=> (state == ST_DEV) && (bit_cnt == 4'h0)
	) else $error("start did not open a transaction");

	a_stop_ends: assert property ( // RQ3
		@(posedge i_link_clk) disable iff (!link_rst_n)
		(stop_det && !(start_det && cap_done)) |=> (state == ST_IDLE) && !sda_oe
	) else $error("stop did not end the transaction");

	a_addr_match_ack: assert property ( // RQ8
		@(posedge i_link_clk) disable iff (!link_rst_n)
		(byte_end && !start_det && !stop_det && (state == ST_DEV) &&
		(shift[7:1] == my_addr)) |=> sda_oe
	) else $error("matching address not acknowledged");

	a_addr_miss_nack: assert property ( // RQ10
		@(posedge i_link_clk) disable iff (!link_rst_n)
		(byte_end && !start_det && !stop_det && (state == ST_DEV) &&
		(shift[7:1] != my_addr)) |=> !sda_oe && (state == ST_SKIP)
	) else $error("foreign address acknowledged");

	a_ack_released: assert property ( // RQ7
		@(posedge i_link_clk) disable iff (!link_rst_n)
		(ack_end && (state != ST_RD)) |=> !sda_oe
	) else $error("data line held after ninth clock");

	a_lock_holds: assert property ( // RQ20
		@(posedge i_link_clk) disable iff (!link_rst_n)
		(byte_end && (state == ST_WR) && pok_s && (ptr >= 3'h4))
		|=> (shadow[4] == $past(shadow[4])) &&
		(shadow[5] == $past(shadow[5])) && (shadow[6] == $past(shadow[6]))
	) else $error("locked register changed while power-ok high");

	a_ptr_advance: assert property ( // RQ22
		@(posedge i_link_clk) disable iff (!link_rst_n)
		(byte_end && !start_det && !stop_det && (state == ST_WR) && wr_ok)
		|=> ptr == ($past(ptr) + 3'h1)
	) else $error("write pointer did not advance");

	a_sda_stable_high: assert property ( // RQ1
		@(posedge i_link_clk) disable iff (!link_rst_n)
		(scl_s && scl_p) |=> $stable(sda_oe) || $past(start_det || stop_det)
	) else $error("data drive changed while clock high");

	a_clock_released: assert property ( // RQ11
		@(posedge i_link_clk) disable iff (!link_rst_n)
		!o_scl_oe && !o_sda_out
	) else $error("slave drove the clock or drove data high");

	a_commit_copy: assert property ( // RQ24
		@(posedge i_core_clk) disable iff (!i_rst_n)
		commit_evt |=> (cfg[0] == shadow[0]) && (cfg[6] == shadow[6])
	) else $error("live registers not updated on commit");
endmodule

// ==== include/icp_pkg.sv ====
// package of constants for the two-wire configuration port
// Behaviour
// RQ1 - data line changes only while clock is low, except start and stop
// RQ2 - data falling while clock high starts a transaction
// RQ3 - data rising while clock high ends the transaction
// RQ4 - master sends stop before each new start
// RQ5 - bytes are eight bits, unlimited count, each followed by acknowledge
// RQ6 - bits travel most significant first in both directions
// RQ7 - ninth clock carries acknowledge, receiver pulls data low
// RQ8 - seven address bits plus direction; acknowledge only on address match
// RQ9 - direction bit 0 writes, 1 reads
// RQ10 - mismatch or not ready leaves data released: not-acknowledge
// RQ11 - slave never drives clock; master makes every pulse
// RQ12 - outputs are open drain: pull low or release only
// RQ13 - works at 100 and 400 kbit per second
// RQ14 - port ignores bus while power-on reset is asserted
// RQ15 - power-on reset returns every register to its initial value
// RQ16 - slave address is one of eight strap-selected values; SLAVE_ADDR holds six distinct (entries 1 and 4, 3 and 6 repeat)
// RQ17 - two transactions: register write and read at current address
// RQ18 - second byte after control byte is register address
// RQ19 - register addresses 0 to 6, address 3 reserved
// RQ20 - registers 4 to 6 writable only while power-ok is low
// RQ21 - valid register address byte is acknowledged
// RQ22 - further write bytes go to consecutive register addresses
// RQ23 - master acknowledge fetches next register; nack then stop ends read
// RQ24 - written values take effect when the write transaction completes
// RQ25 - clock and data pass synchronisers; edges found from synced samples
// RQ26 - three-bit strap select decoded into address at reset release
package icp_pkg;
	localparam int REG_COUNT = 7;
	localparam logic [7:0] ADDR_RSVD = 8'h03;
	localparam logic [7:0] ADDR_LOCK_LO = 8'h04;
	localparam logic [7:0] ADDR_LAST = 8'h06;
	localparam logic [2:0] PTR_END = 3'h7;
	localparam logic [7:0] RST_VAL [0:6] =
		'{8'h00, 8'h00, 8'h01, 8'h00, 8'h7C, 8'h00, 8'h21};
	localparam logic [6:0] SLAVE_ADDR [0:7] =
		'{7'h46, 7'h56, 7'h4E, 7'h5E, 7'h56, 7'h57, 7'h5E, 7'h5F};
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_END = 4'h9;
	localparam logic [1:0] CAP_LOAD = 2'h2;
	localparam logic [1:0] CAP_DONE = 2'h3;
	// fast-mode bit time against link sampling period
	localparam int FAST_BIT_NS = 2500;
	localparam int LINK_PERIOD_NS = 125;
	localparam int SAMPLES_PER_BIT = FAST_BIT_NS / LINK_PERIOD_NS;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DEV = 3'b001,
		ST_REGA = 3'b010,
		ST_WR = 3'b011,
		ST_RD = 3'b100,
		ST_SKIP = 3'b101
	} icp_state_t;
endpackage

// ==== verif/icp_master_model.sv ====
// bus master model that drives the two-wire port
`timescale 1ns/1ps
module icp_master_model (
	input wire logic i_link_clk, // pacing clock
	input wire logic i_sda, // resolved data wire
	output logic o_scl_oe, // high pulls clock low
	output logic o_sda_oe // high pulls data low
);
	// ==========================================
	// bus actions, quarter bit of five link clocks
	initial begin
		o_scl_oe = 1'b0;
		o_sda_oe = 1'b0;
	end
	task automatic q();
		repeat (5) @(posedge i_link_clk);
	endtask
	task automatic bitx(input logic b, output logic r);
		o_sda_oe <= ~b;
		q();
		o_scl_oe <= 1'b0;
		q();
		r = i_sda;
		q();
		o_scl_oe <= 1'b1;
		q();
	endtask
	task automatic start();
		@(posedge i_link_clk);
		o_sda_oe <= 1'b1;
		q();
		o_scl_oe <= 1'b1;
		q();
	endtask
	task automatic stop();
		o_sda_oe <= 1'b1;
		q();
		o_scl_oe <= 1'b0;
		q();
		o_sda_oe <= 1'b0;
		q();
		q();
	endtask
	task automatic xfer(input logic [7:0] d, input logic a,
		output logic [7:0] rd, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], rd[i]);
		end
		bitx(a, ack);
	endtask
endmodule

// ==== verif/icp_slave_tb.sv ====
// self-checking bench for the two-wire configuration port
`timescale 1ns/1ps
module icp_slave_tb;
	import icp_pkg::*;
	localparam int LIMIT = 100000;
	logic core_clk, link_clk, rst_n, power_ok, m_scl_oe, m_sda_oe;
	logic scl_out, scl_oe, sda_out, sda_oe, ack;
	logic [2:0] sel;
	logic [7:0] regs [0:6];
	logic [7:0] exp_r [0:6];
	logic [7:0] rd, d;
	int failures = 0;
	int n_checks = 0;
	int cycles = 0;
	int seed;
	wire logic scl = ~(m_scl_oe | scl_oe);
	wire logic sda = ~(m_sda_oe | sda_oe);
	icp_slave dut (.i_core_clk(core_clk), .i_rst_n(rst_n),
		.i_link_clk(link_clk), .i_scl(scl), .o_scl_out(scl_out),
		.o_scl_oe(scl_oe), .i_sda(sda), .o_sda_out(sda_out),
		.o_sda_oe(sda_oe), .i_power_ok_in(power_ok), .i_addr_sel(sel),
		.o_northbridge_offset_ctrl(regs[0]), .o_core_offset_ctrl(regs[1]),
		.o_power_save_cfg(regs[2]), .o_phase_gate_level_ctrl(regs[4]),
		.o_min_phase_droop_cfg(regs[5]), .o_slew_alignment_cfg(regs[6]));
	icp_master_model m (.i_link_clk(link_clk), .i_sda(sda),
		.o_scl_oe(m_scl_oe), .o_sda_oe(m_sda_oe));
	// ==========================================
	// clocks and run limit
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	initial begin
		link_clk = 1'b0;
		#37;
		forever #62.5 link_clk = ~link_clk;
	end
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			failures++;
			summarize();
		end
	end
	// ==========================================
	// helpers
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	function automatic logic [7:0] rd_exp(input int a);
		if (a == 3 || a > 6) begin
			return 8'h00;
		end
		return exp_r[a];
	endfunction
	task automatic send(input logic [7:0] v, input logic want);
		m.xfer(v, 1'b1, rd, ack);
		check({7'h00, ack}, {7'h00, ~want});
	endtask
	task automatic chk_regs();
		repeat (4) @(posedge core_clk);
		check({5'h00, scl_out, scl_oe, sda_out}, 8'h00);
		for (int i = 0; i < 7; i++) begin
			if (i != 3) begin
				check(regs[i], exp_r[i]);
			end
		end
	endtask
	// reset spans three link periods so the link side sees it
	task automatic do_reset(input logic [2:0] s);
		@(posedge core_clk);
		rst_n <= 1'b0;
		sel <= s;
		power_ok <= 1'b0;
		repeat (48) @(posedge core_clk);
		for (int i = 0; i < 7; i++) begin
			exp_r[i] = RST_VAL[i];
		end
		chk_regs();
		rst_n <= 1'b1;
		repeat (8) @(posedge link_clk);
	endtask
	// ==========================================
	// main sequence
	initial begin
		seed = 32'h9B38;
		rst_n = 1'b0;
		power_ok = 1'b0;
		sel = 3'h0;
		do_reset(3'($random(seed)));
		m.start();
		send({SLAVE_ADDR[sel] ^ 7'h01, 1'b0}, 1'b0);
		m.stop();
		m.start();
		send({SLAVE_ADDR[sel], 1'b0}, 1'b1);
		send(8'h02, 1'b1);
		for (int a = 2; a <= 7; a++) begin
			d = 8'($random(seed));
			send(d, a <= 6);
			if (a <= 6 && a != 3) begin
				exp_r[a] = d;
			end
		end
		m.stop();
		chk_regs();
		@(posedge core_clk) power_ok <= 1'b1;
		m.start();
		send({SLAVE_ADDR[sel], 1'b0}, 1'b1);
		send(8'h04, 1'b1);
		send(~exp_r[4], 1'b0);
		m.stop();
		chk_regs();
		m.start();
		send({SLAVE_ADDR[sel], 1'b0}, 1'b1);
		send(8'h02, 1'b1);
		m.stop();
		m.start();
		send({SLAVE_ADDR[sel], 1'b1}, 1'b1);
		for (int a = 2; a <= 7; a++) begin
			m.xfer(8'hFF, a == 7, rd, ack);
			check(rd, rd_exp(a));
		end
		m.stop();
		do_reset(3'($random(seed)));
		m.start();
		send({SLAVE_ADDR[sel], 1'b0}, 1'b1);
		send(8'h00, 1'b1);
		d = 8'($random(seed));
		send(d, 1'b1);
		exp_r[0] = d;
		m.stop();
		chk_regs();
		summarize();
	end
endmodule
